// [src/io_bus_interface_status_ports.sv]
`timescale 1ns/1ps
// Notes on behaviour
// - Scan option shows watchdog on bit 2.
// - Interrupt port: live line, bit3 0, high ones.
// - Minute event latched on selected reserve edge.
// - Time port bit 1 shows latch; read clears.
// - Only first instance drives minute interrupt.
// - Time port: bit1 latch, others fixed.
// - Accesses stretched by 1 MHz wait ticks.
// - Two-second timeout lights lamp, resets peripherals.
// - Fault port: bit3 flag, read clears.
// - Fault port write drives test pattern.
// - Control write bits per instance.
// - Control read returns contacts and switches.
// - Decode only when area select qualifies.
// - Guarded route drops interrupt after timeout.
// - Interrupt enable bit needs its option.
// - Fault inhibit blocks writes until flag read.
// - Watchdog counts only with test option.
// - Peripheral reset is stop OR timeout.
module io_bus_interface_status_ports #(
	parameter bit FIRST_INSTANCE = 1'b1,
	parameter int WD_CYCLES      = io_bridge_pkg::WD_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic [11:0] addr,
	input  wire logic [7:0]  dataIn,
	input  wire logic        memRead,
	input  wire logic        memWrite,
	input  wire logic        areaSelect,
	output logic      [7:0]  dataOut,
	output logic             ready,
	output logic      [11:0] ioAddr,
	output logic      [7:0]  ioDataOut,
	output logic             ioDataOe,
	input  wire logic [7:0]  ioDataIn,
	output logic             ioRead,
	output logic             ioWrite,
	input  wire logic        process_interrupt_line_n,
	output logic             processIrq,
	output logic             minute_interrupt,
	input  wire logic        reserve_input,
	input  wire logic        fan_contact,
	input  wire logic        overtemp_contact,
	input  wire logic        door_contact,
	input  wire logic        systemJumper,
	input  wire logic        outputInhibitSwitch,
	input  wire logic        cpu_not_operational,
	output logic             peripheral_reset_out,
	output logic             watchdogAlarm_n,
	output logic             local_bus_enable,
	output logic             static_lamp_out,
	input  wire logic        scan_option,
	input  wire logic        sw_inhibit_option,
	input  wire logic        counter_test_option,
	input  wire logic        falling_edge_select,
	input  wire logic        rising_edge_select,
	input  wire logic        minute_route_option,
	input  wire logic        fault_read_option,
	input  wire logic        fault_inhibit_option,
	input  wire logic        guarded_int_route,
	input  wire logic        unguarded_int_route
);
	io_bus_if bus ();
	logic [2:0] intSync;
	logic [2:0] resSync;
	logic [4:0] contactSync [3];
	logic       resLevel;
	logic       resPrev;
	logic [4:0] resSettle;
	logic       minuteLatch;
	logic       faultFlag;
	logic       writeBlock;
	logic       intEnable;
	logic       active;
	logic       activeWrite;
	logic       expired;
	logic       wdTrigger;
	logic [7:0] control;
	logic [7:0] readValue;
	logic [7:0] contacts;
	logic       intLine;
	logic       inRange;
	logic       decoded;
	logic       finish;
	logic       readFinish;
	logic       writeFinish;
	logic       minuteEdge;
	logic       compareFault;
	logic       writesBlocked;
	logic       intGate;
	logic       ioCycle;
	function automatic logic hit(input logic [11:0] a, input logic [11:0] p);
		hit = (a == p);
	endfunction
	// Pins from outside pass three stages; a level counts once the second
	// and third stages agree.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			intSync <= 3'b111;
			resSync <= 3'b000;
		end else begin
			intSync <= {intSync[1:0], process_interrupt_line_n};
			resSync <= {resSync[1:0], reserve_input};
		end
	end
	genvar g;
	generate
		for (g = 0; g < 3; g++) begin : gContact
			if (g == 0) begin : gFirst
				always_ff @(posedge clock or posedge sys_rst) begin
					if (sys_rst) begin
						contactSync[g] <= 5'h00;
					end else begin
						contactSync[g] <= {fan_contact, overtemp_contact,
							door_contact, systemJumper, outputInhibitSwitch};
					end
				end
			end else begin : gNext
				always_ff @(posedge clock or posedge sys_rst) begin
					if (sys_rst) begin
						contactSync[g] <= 5'h00;
					end else begin
						contactSync[g] <= contactSync[g - 1];
					end
				end
			end
		end
	endgenerate
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			intLine <= 1'b1;
			resLevel <= 1'b0;
			resPrev <= 1'b0;
			resSettle <= 5'h00;
			contacts <= 8'h20;
		end else begin
			if (intSync[1] == intSync[2]) begin
				intLine <= intSync[2];
			end
			if (resSync[1] == resSync[2]) begin
				resLevel <= resSync[2];
			end
			resPrev <= resLevel;
			resSettle <= {resSettle[3:0], 1'b1};
			if (contactSync[1] == contactSync[2]) begin
				contacts <= {contactSync[2][0], 1'b0, 1'b1,
					contactSync[2][1], contactSync[2][2], contactSync[2][3],
					contactSync[2][4], resLevel};
			end
		end
	end
	// Ports outside the status window go through to the I/O modules.
	assign decoded     = areaSelect && (memRead || memWrite);
	assign inRange     = addr >= io_bridge_pkg::ADDR_RANGE_LO
		&& addr <= io_bridge_pkg::ADDR_RANGE_HI;
	assign finish      = bus.done;
	assign readFinish  = finish && !bus.write;
	assign writeFinish = finish && bus.write;
	assign ioCycle     = !inRange || hit(addr, io_bridge_pkg::ADDR_FAULT);
	assign writesBlocked = contacts[7] || writeBlock;
	// A pin resting high through reset must not pass for a rising edge, so
	// edges count only once both level stages hold real pin samples.
	assign minuteEdge  = resSettle[4]
		&& ((rising_edge_select && resLevel && !resPrev)
		|| (falling_edge_select && !resLevel && resPrev));
	assign compareFault = activeWrite && fault_read_option && ioCycle
		&& ioDataOe && (ioDataIn != dataIn);
	assign wdTrigger   = writeFinish && hit(addr, io_bridge_pkg::ADDR_CONTROL)
		&& dataIn[io_bridge_pkg::BIT_WD_TRIG];
	assign bus.req     = active;
	assign bus.write   = activeWrite;
	assign bus.addr    = addr;
	assign bus.wdata   = dataIn;
	wait_timer #(
		.TICK_CYCLES (io_bridge_pkg::TICK_CYCLES),
		.WAIT_TICKS  (io_bridge_pkg::WAIT_TICKS)
	) uWait (
		.clock   (clock),
		.sys_rst (sys_rst),
		.bus     (bus)
	);
	watchdog_timer #(
		.LIMIT (WD_CYCLES)
	) uWatchdog (
		.clock     (clock),
		.sys_rst   (sys_rst),
		.enable    (counter_test_option),
		.retrigger (wdTrigger),
		.expired   (expired)
	);
	always_comb begin
		readValue = io_bridge_pkg::UNUSED_READ;
		if (hit(addr, io_bridge_pkg::ADDR_INT_SCAN)) begin
			readValue = io_bridge_pkg::INT_SCAN_FIX;
			readValue[io_bridge_pkg::BIT_INT_LINE] = intLine;
			readValue[1] = 1'b1;
			readValue[io_bridge_pkg::BIT_WD_SCAN] =
				scan_option ? !expired : 1'b1;
		end else if (hit(addr, io_bridge_pkg::ADDR_MINUTE)) begin
			readValue = io_bridge_pkg::MINUTE_FIX;
			readValue[io_bridge_pkg::BIT_MINUTE] = !minuteLatch;
		end else if (hit(addr, io_bridge_pkg::ADDR_FAULT)) begin
			readValue = io_bridge_pkg::FAULT_FIX;
			readValue[io_bridge_pkg::BIT_FAULT] = !faultFlag;
		end else if (hit(addr, io_bridge_pkg::ADDR_CONTROL)) begin
			readValue = contacts;
		end else if (!inRange) begin
			readValue = ioDataIn;
		end
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			active <= 1'b0;
			activeWrite <= 1'b0;
		end else if (finish || !decoded) begin
			active <= 1'b0;
			activeWrite <= 1'b0;
		end else if (!active && !ready) begin
			active <= 1'b1;
			activeWrite <= memWrite;
		end
	end
	// A set arriving with the clearing read wins, so no event is lost.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			minuteLatch <= 1'b0;
			faultFlag <= 1'b0;
			writeBlock <= 1'b0;
		end else begin
			if (minuteEdge) begin
				minuteLatch <= 1'b1;
			end else if (readFinish && hit(addr, io_bridge_pkg::ADDR_MINUTE)) begin
				minuteLatch <= 1'b0;
			end
			if (compareFault) begin
				faultFlag <= 1'b1;
				writeBlock <= fault_inhibit_option;
			end else if (readFinish && hit(addr, io_bridge_pkg::ADDR_FAULT)) begin
				faultFlag <= 1'b0;
				writeBlock <= 1'b0;
			end
		end
	end
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			control <= io_bridge_pkg::CONTROL_RESET;
		end else if (writeFinish && hit(addr, io_bridge_pkg::ADDR_CONTROL)) begin
			control <= FIRST_INSTANCE ? dataIn
				: {control[7], dataIn[6], control[5:2], dataIn[1],
				control[0]};
		end
	end
	assign intEnable = !sw_inhibit_option
		|| control[io_bridge_pkg::BIT_INT_EN];
	assign intGate = FIRST_INSTANCE && intEnable
		&& ((guarded_int_route && !expired) || unguarded_int_route);
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			dataOut <= 8'h00;
			ready <= 1'b0;
			ioAddr <= 12'h000;
			ioDataOut <= 8'h00;
			ioDataOe <= 1'b0;
			ioRead <= 1'b0;
			ioWrite <= 1'b0;
			processIrq <= 1'b0;
			minute_interrupt <= 1'b0;
			peripheral_reset_out <= 1'b1;
			watchdogAlarm_n <= 1'b1;
			local_bus_enable <= 1'b1;
			static_lamp_out <= 1'b0;
		end else begin
			ready <= finish;
			if (readFinish) begin
				dataOut <= readValue;
			end
			// The pattern write drives the I/O bus without ioWrite, but is compared with ioDataIn like other writes.
			ioAddr <= addr;
			ioDataOut <= dataIn;
			ioDataOe <= active && activeWrite && ioCycle && !finish
				&& !writesBlocked;
			ioWrite <= active && activeWrite && ioCycle && !finish
				&& !writesBlocked && !hit(addr, io_bridge_pkg::ADDR_FAULT);
			ioRead <= active && !activeWrite && !inRange && !finish;
			processIrq <= intGate && !intLine;
			minute_interrupt <= FIRST_INSTANCE && minute_route_option
				&& intEnable && minuteLatch;
			peripheral_reset_out <= cpu_not_operational || expired;
			watchdogAlarm_n <= !expired;
			local_bus_enable <= FIRST_INSTANCE
				? !control[io_bridge_pkg::BIT_LOCAL_EN] : 1'b1;
			static_lamp_out <= control[io_bridge_pkg::BIT_LAMP] || expired;
		end
	end
endmodule

// [src/io_bridge_pkg.sv]
package io_bridge_pkg;
	localparam logic [11:0] ADDR_INT_SCAN  = 12'hfd9;
	localparam logic [11:0] ADDR_MINUTE    = 12'hfda;
	localparam logic [11:0] ADDR_FAULT     = 12'hfdb;
	localparam logic [11:0] ADDR_CONTROL   = 12'hfdd;
	localparam logic [11:0] ADDR_RANGE_LO  = 12'hfd0;
	localparam logic [11:0] ADDR_RANGE_HI  = 12'hfdf;
	localparam int          BIT_INT_LINE   = 0;
	localparam int          BIT_WD_SCAN    = 2;
	localparam int          BIT_MINUTE     = 1;
	localparam int          BIT_FAULT      = 3;
	localparam int          BIT_LOCAL_EN   = 0;
	localparam int          BIT_LAMP       = 1;
	localparam int          BIT_WD_TRIG    = 6;
	localparam int          BIT_INT_EN     = 7;
	localparam logic [7:0]  INT_SCAN_FIX   = 8'hf0;
	localparam logic [7:0]  MINUTE_FIX     = 8'hf0;
	localparam logic [7:0]  FAULT_FIX      = 8'hf7;
	localparam logic [7:0]  UNUSED_READ    = 8'hff;
	localparam logic [7:0]  CONTROL_RESET  = 8'h80;
	localparam int          CLOCK_HZ       = 10000000;
	localparam int          TICK_HZ        = 1000000;
	localparam int          TICK_CYCLES    = CLOCK_HZ / TICK_HZ;
	localparam int          WAIT_TICKS     = 2;
	localparam int          WD_TIME_MS     = 2000;
	localparam int          WD_CYCLES      = (CLOCK_HZ / 1000) * WD_TIME_MS;
endpackage

// [src/io_bus_if.sv]
`timescale 1ns/1ps
interface io_bus_if;
	logic       req;
	logic       write;
	logic [11:0] addr;
	logic [7:0] wdata;
	logic       done;
	modport master (output req, output write, output addr, output wdata,
		input done);
	modport slave (input req, input write, input addr, input wdata,
		output done);
endinterface

// [src/wait_timer.sv]
`timescale 1ns/1ps
module wait_timer #(
	parameter int TICK_CYCLES = 10,
	parameter int WAIT_TICKS  = 2
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	io_bus_if.slave   bus
);
	logic [7:0] divider;
	logic [3:0] ticks;
	logic       tick;
	assign tick = (divider == 8'(TICK_CYCLES - 1));
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			divider <= 8'h00;
		end else if (tick) begin
			divider <= 8'h00;
		end else begin
			divider <= divider + 8'h01;
		end
	end
	// Access length is counted on the free-running 1 MHz tick, so the first
	// slow bus period is partial and depends on where in the tick period it began.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			ticks <= 4'h0;
			bus.done <= 1'b0;
		end else if (!bus.req || bus.done) begin
			ticks <= 4'h0;
			bus.done <= 1'b0;
		end else if (tick) begin
			ticks <= ticks + 4'h1;
			bus.done <= (ticks == 4'(WAIT_TICKS - 1));
		end
	end
endmodule

// [src/watchdog_timer.sv]
`timescale 1ns/1ps
module watchdog_timer #(
	parameter int LIMIT = 20000000
) (
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic enable,
	input  wire logic retrigger,
	output logic      expired
);
	logic [31:0] count;
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			count <= 32'h00000000;
			expired <= 1'b0;
		end else if (!enable || retrigger) begin
			count <= 32'h00000000;
			expired <= 1'b0;
		end else if (count == 32'(LIMIT - 1)) begin
			expired <= 1'b1;
		end else begin
			count <= count + 32'h00000001;
		end
	end
endmodule

// [sim/io_bus_interface_status_ports_asserts.sv]
`timescale 1ns/1ps
module io_bus_interface_status_ports_asserts #(
	parameter bit FIRST_INSTANCE = 1'b1,
	parameter int WD_CYCLES      = 200
) (
	input wire logic        clock,
	input wire logic        sys_rst,
	input wire logic [11:0] addr,
	input wire logic [7:0]  dataIn,
	input wire logic        memRead,
	input wire logic        memWrite,
	input wire logic        areaSelect,
	input wire logic        ready,
	input wire logic        processIrq,
	input wire logic        minute_interrupt,
	input wire logic        cpu_not_operational,
	input wire logic        peripheral_reset_out,
	input wire logic        watchdogAlarm_n,
	input wire logic        static_lamp_out,
	input wire logic        counter_test_option,
	input wire logic        minute_route_option,
	input wire logic        guarded_int_route,
	input wire logic        unguarded_int_route
);
	// The design restarts its count on the edge that raises ready, one cycle before this one, so this one only lags.
	int  wdCount;
	wire isControl = addr == io_bridge_pkg::ADDR_CONTROL;
	wire trigger   = ready && memWrite && areaSelect && isControl &&
		dataIn[io_bridge_pkg::BIT_WD_TRIG];
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst)
			wdCount <= 0;
		else if (trigger)
			wdCount <= 0;
		else if (wdCount < WD_CYCLES + 50)
			wdCount <= wdCount + 1;
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	sequence s_take;
		areaSelect && (memRead || memWrite) && !$past(memRead || memWrite);
	endsequence
	sequence s_expired;
		!watchdogAlarm_n [*3];
	endsequence
	property p_wait;
		s_take |-> !ready [*8] ##[1:20] ready;
	endproperty
	property p_qualified;
		ready |-> $past(areaSelect) && $past(memRead || memWrite);
	endproperty
	property p_route;
		(!FIRST_INSTANCE || !minute_route_option) |-> !minute_interrupt;
	endproperty
	property p_no_wd;
		!counter_test_option |-> watchdogAlarm_n;
	endproperty
	property p_lamp;
		!watchdogAlarm_n |-> static_lamp_out && peripheral_reset_out;
	endproperty
	property p_stop;
		$rose(cpu_not_operational) |-> ##[0:4] peripheral_reset_out;
	endproperty
	property p_early;
		$fell(watchdogAlarm_n) |-> wdCount >= WD_CYCLES - 30;
	endproperty
	property p_guard;
		s_expired ##0 (guarded_int_route && !unguarded_int_route)
			|-> !processIrq;
	endproperty
	a_wait: assert property (p_wait)
		else $error("Access length out of range");
	a_qualified: assert property (p_qualified)
		else $error("Ready without qualified request");
	a_route: assert property (p_route)
		else $error("Minute interrupt driven while not routed");
	a_no_wd: assert property (p_no_wd)
		else $error("Watchdog expired without its option");
	a_lamp: assert property (p_lamp)
		else $error("Timeout without lamp or peripheral reset");
	a_stop: assert property (p_stop)
		else $error("Stop did not reset peripherals");
	a_early: assert property (p_early)
		else $error("Watchdog expired too soon after trigger");
	a_guard: assert property (p_guard)
		else $error("Interrupt forwarded after timeout");
endmodule

bind io_bus_interface_status_ports io_bus_interface_status_ports_asserts #(
	.FIRST_INSTANCE(FIRST_INSTANCE),
	.WD_CYCLES(WD_CYCLES)
) i_checker (.*);

// [sim/io_module_model.sv]
`timescale 1ns/1ps
module io_module_model (
	input  wire logic        clock,
	input  wire logic        ioRead,
	input  wire logic        ioWrite,
	input  wire logic [11:0] ioAddr,
	input  wire logic [7:0]  ioDataOut,
	input  wire logic        ioDataOe,
	input  wire logic        corrupt,
	output logic      [7:0]  ioDataIn,
	output logic      [7:0]  lastWrite
);
	logic [7:0] rdData = 8'h00;
	// Idle bus toggles so a stale value can never pass for read data.
	assign ioDataIn = ioDataOe ? ioDataOut ^ {7'h00, corrupt} : rdData;
	always @(posedge clock) begin
		rdData <= ioRead ? ioAddr[7:0] ^ 8'h5a : ~rdData;
		if (ioDataOe)
			lastWrite <= ioDataOut;
	end
endmodule

// [sim/io_bus_interface_status_ports_tb_top.sv]
`timescale 1ns/1ps
module io_bus_interface_status_ports_tb_top;
	localparam int WD = 200;
	logic        clock = 1'b0, sys_rst = 1'b1, corrupt = 1'b0;
	logic [11:0] addr = 12'h000, ioAddr;
	logic [7:0]  dataIn = 8'h00, dataOut, ioDataOut, ioDataIn, lastWrite;
	logic        memRead = 1'b0, memWrite = 1'b0, areaSelect = 1'b0;
	logic        ready, ioDataOe, ioRead, ioWrite, processIrq;
	logic        minute_interrupt, peripheral_reset_out, watchdogAlarm_n;
	logic        local_bus_enable, static_lamp_out;
	logic        irq2, minute2, localEn2, lamp2;
	logic        process_interrupt_line_n = 1'b1, reserve_input = 1'b0;
	logic        fan_contact = 1'b0, overtemp_contact = 1'b0;
	logic        door_contact = 1'b0, systemJumper = 1'b0;
	logic        outputInhibitSwitch = 1'b0, cpu_not_operational = 1'b0;
	logic        scan_option = 1'b0, sw_inhibit_option = 1'b0;
	logic        counter_test_option = 1'b0, falling_edge_select = 1'b0;
	logic        rising_edge_select = 1'b1, minute_route_option = 1'b0;
	logic        fault_read_option = 1'b0, fault_inhibit_option = 1'b0;
	logic        guarded_int_route = 1'b0, unguarded_int_route = 1'b0;
	logic [7:0]  expq[$];
	int          mismatches = 0, samples_checked = 0, cycles = 0;
	int          ioWrites = 0, n0;
	always #50 clock = ~clock;
	io_bus_interface_status_ports #(.WD_CYCLES(WD)) i_dut (.*);
	io_bus_interface_status_ports #(.FIRST_INSTANCE(1'b0), .WD_CYCLES(WD))
		i_dut2 (.*, .dataOut(), .ready(), .ioAddr(), .ioDataOut(),
		.ioDataOe(), .ioRead(), .ioWrite(), .processIrq(irq2),
		.minute_interrupt(minute2), .peripheral_reset_out(),
		.watchdogAlarm_n(), .local_bus_enable(localEn2),
		.static_lamp_out(lamp2));
	io_module_model i_io (.*);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("Checked %0d, mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic acc(input logic wr, input logic [11:0] a, input logic [7:0] d);
		int n;
		@(posedge clock);
		addr <= a;
		dataIn <= d;
		areaSelect <= 1'b1;
		memWrite <= wr;
		memRead <= !wr;
		n = 0;
		do begin
			@(negedge clock);
			n++;
		end while (ready !== 1'b1 && n < 60);
		if (n >= 60)
			mismatches++;
		@(posedge clock);
		memRead <= 1'b0;
		memWrite <= 1'b0;
		areaSelect <= 1'b0;
		@(posedge clock);
	endtask
	task automatic rd(input logic [11:0] a, input logic [7:0] e);
		expq.push_back(e);
		acc(1'b0, a, 8'h00);
	endtask
	task automatic restart(input logic [9:0] o);
		@(posedge clock);
		sys_rst <= 1'b1;
		{unguarded_int_route, guarded_int_route, fault_inhibit_option,
			fault_read_option, minute_route_option, rising_edge_select,
			falling_edge_select, counter_test_option, sw_inhibit_option,
			scan_option} <= o;
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		repeat (6) @(posedge clock);
	endtask
	always @(negedge clock)
		if (ready === 1'b1 && memRead === 1'b1)
			check(dataOut, expq.pop_front());
	always @(posedge ioWrite)
		ioWrites++;
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			mismatches++;
			conclude();
		end
	end
	initial begin
		void'($urandom(32'hbc5b));
		restart(10'h131);
		repeat (3) begin
			{fan_contact, overtemp_contact, door_contact, systemJumper,
				outputInhibitSwitch, process_interrupt_line_n} <= 6'($urandom);
			repeat (6) @(posedge clock);
			rd(12'hfd9, {5'h1e, 2'h3, process_interrupt_line_n});
			rd(12'hfdd, {outputInhibitSwitch, 2'h1, systemJumper, door_contact,
				overtemp_contact, fan_contact, reserve_input});
			check(processIrq, !process_interrupt_line_n);
			check(irq2, 8'h00);
		end
		rd(12'hfd0, 8'hff);
		$display("Test status ports done");
		for (int e = 0; e < 2; e++) begin
			reserve_input <= (e == 0);
			restart(e == 1 ? 10'h031 : 10'h029);
			reserve_input <= (e == 1);
			repeat (8) @(posedge clock);
			check(minute_interrupt, 8'h01);
			check(minute2, 8'h00);
			rd(12'hfda, 8'hf0);
			rd(12'hfda, 8'hf2);
			check(minute_interrupt, 8'h00);
			reserve_input <= (e == 0);
			repeat (8) @(posedge clock);
			rd(12'hfda, 8'hf2);
		end
		$display("Test minute sync done");
		{fan_contact, overtemp_contact, door_contact, systemJumper,
			outputInhibitSwitch, process_interrupt_line_n} <= 6'h01;
		restart(10'h0c0);
		acc(1'b1, 12'hfdb, 8'ha5);
		check(lastWrite, 8'ha5);
		rd(12'hfdb, 8'hff);
		corrupt <= 1'b1;
		acc(1'b1, 12'h010, 8'h3c);
		corrupt <= 1'b0;
		n0 = ioWrites;
		acc(1'b1, 12'h011, 8'h77);
		check(8'(ioWrites - n0), 8'h00);
		rd(12'hfdb, 8'hf7);
		rd(12'hfdb, 8'hff);
		acc(1'b1, 12'h012, 8'h99);
		check(8'(ioWrites - n0), 8'h01);
		rd(12'h010, 8'h4a);
		$display("Test bus fault done");
		process_interrupt_line_n <= 1'b0;
		restart(10'h105);
		for (int i = 0; i < 4; i++) begin
			acc(1'b1, 12'hfdd, i[0] ? 8'hc1 : 8'hc2);
			check({local_bus_enable, static_lamp_out},
				i[0] ? 8'h00 : 8'h03);
			check({localEn2, lamp2}, i[0] ? 8'h02 : 8'h03);
			check(processIrq, 8'h01);
			repeat (100) @(posedge clock);
			check(watchdogAlarm_n, 8'h01);
		end
		repeat (250) @(posedge clock);
		check({watchdogAlarm_n, static_lamp_out, peripheral_reset_out,
			processIrq}, 8'h06);
		rd(12'hfd9, 8'hf2);
		restart(10'h204);
		repeat (300) @(posedge clock);
		check({watchdogAlarm_n, processIrq}, 8'h01);
		$display("Test watchdog done");
		restart(10'h102);
		repeat (300) @(posedge clock);
		check(watchdogAlarm_n, 8'h01);
		acc(1'b1, 12'hfdd, 8'h00);
		check(processIrq, 8'h00);
		acc(1'b1, 12'hfdd, 8'h80);
		check(processIrq, 8'h01);
		cpu_not_operational <= 1'b1;
		repeat (6) @(posedge clock);
		check(peripheral_reset_out, 8'h01);
		cpu_not_operational <= 1'b0;
		repeat (6) @(posedge clock);
		check(peripheral_reset_out, 8'h00);
		$display("Test inhibit and stop done");
		conclude();
	end
endmodule
